// ===== rtl/flash_status_pkg.sv
// Constants, types and protection decode for the flash status word
package flash_status_pkg;

   // Status word bit positions
   localparam int BIT_BUSY = 0;
   localparam int BIT_LATCH = 1;
   localparam int BIT_LEVEL_LO = 2;
   localparam int BIT_LEVEL_HI = 4;
   localparam int BIT_RSVD_LO = 5;
   localparam int BIT_RSVD_HI = 6;
   localparam int BIT_LOCK = 7;

   // Power-up values
   localparam logic RESET_BUSY = 1'h0;
   localparam logic RESET_LATCH = 1'h0;
   localparam logic [2:0] RESET_LEVEL = 3'h7;
   localparam logic RESET_LOCK = 1'h0;
   localparam logic [1:0] RESET_RSVD = 2'h0;
   localparam logic RESET_WP_LEVEL = 1'h1;

   // Array geometry: block index is address bits 21..16
   localparam int ADDR_W = 24;
   localparam int BLOCK_LSB = 16;
   localparam int BLOCK_MSB = 21;
   localparam int BLOCK_W = 6;
   localparam logic [6:0] BLOCK_COUNT = 7'h40;

   // Protection level codes
   localparam logic [2:0] LEVEL_NONE = 3'h0;
   localparam logic [2:0] LEVEL_ALL = 3'h7;

   // Array operations
   typedef enum logic [1:0]
   {
      OP_PAGE_PROGRAM = 2'h0,
      OP_SECTOR_ERASE = 2'h1,
      OP_BLOCK_ERASE = 2'h2,
      OP_CHIP_ERASE = 2'h3
   } array_op_t;

   // Array engine state
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'h1,
      ST_BUSY = 2'h2
   } engine_state_t;

   // Lowest protected block for a level; 64 means nothing protected
   function automatic logic [6:0] first_protected_block(input logic [2:0] level);
      logic [6:0] span;
      span = 7'h1 << (level - 3'h1);
      if (level == LEVEL_NONE)
      begin
         return BLOCK_COUNT;
      end
      else if (level == LEVEL_ALL)
      begin
         return 7'h0;
      end
      else
      begin
         return BLOCK_COUNT - span;
      end
   endfunction

endpackage

// ===== rtl/flash_status_protect.sv
// Status word, write-enable latch and block protection of the serial flash
//
// Summary of operation
// - Bit 0 is busy: 1 during program or erase, 0 at power-up, not writable.
// - Bit 1 shows the write-enable latch, powers up 0, read-only.
// - Program or erase is ignored while the write-enable latch is 0.
// - Latch clears at power-up, write-disable and every status write.
// - Latch clears when page program, sector, block or chip erase finishes.
// - Protection level bits 2..4 are writable and power up as all ones.
// - Bits 5 and 6 read zero and ignore writes.
// - Bit 7 lock makes the level bits read-only; powers up 0.
// - Status write changes only level bits and lock bit.
// - Whole word is volatile; every power-up restores defaults.
// - Level 0 none, 1..6 top 1/64..1/2, 7 whole array.
// - Program or erase into protected region is refused regardless of latch.
// - Chip erase refused unless all level bits are zero.
// - Lock acts only with protect pin low; pin high ignores lock.
`timescale 1ns/100ps
module flash_status_protect
   import flash_status_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic WP_B,
   input wire logic WRITE_ENABLE_CMD,
   input wire logic WRITE_DISABLE_CMD,
   input wire logic STATUS_WRITE_CMD,
   input wire logic [7:0] STATUS_WRITE_DATA,
   input wire logic OP_REQ,
   input wire flash_status_pkg::array_op_t OP_KIND,
   input wire logic [flash_status_pkg::ADDR_W-1:0] OP_ADDR,
   input wire logic OP_DONE,
   output logic [7:0] STATUS_WORD,
   output logic OP_START,
   output logic OP_REFUSED
);
   import flash_status_pkg::*;

   engine_state_t state_reg;
   engine_state_t state_next;
   logic write_enable_latch_reg;
   logic [2:0] level_reg;
   logic lock_reg;
   logic wp_s1_reg;
   logic wp_s2_reg;
   logic wp_s3_reg;
   logic wp_level_reg;
   logic op_start_reg;
   logic op_refused_reg;
   logic busy;
   logic in_protected;
   logic op_allowed;
   logic op_take;
   logic wren_take;
   logic write_disable_take;
   logic sw_take;
   logic locked;
   logic [BLOCK_W-1:0] op_block;

   assign busy = (state_reg == ST_BUSY);
   assign op_block = OP_ADDR[BLOCK_MSB:BLOCK_LSB];
   assign locked = !wp_level_reg && lock_reg;

   // Commands other than polling are ignored while busy
   assign op_take = OP_REQ && !busy;
   assign wren_take = WRITE_ENABLE_CMD && !busy;
   assign write_disable_take = WRITE_DISABLE_CMD && !busy;
   assign sw_take = STATUS_WRITE_CMD && !busy && write_enable_latch_reg;

   protect_decode u_decode
   (
      .level(level_reg),
      .block(op_block),
      .in_protected(in_protected)
   );

   // Acceptance gate for array operations
   always_comb
   begin
      op_allowed = write_enable_latch_reg;
      if (OP_KIND == OP_CHIP_ERASE)
      begin
         op_allowed = op_allowed && (level_reg == LEVEL_NONE);
      end
      else
      begin
         op_allowed = op_allowed && !in_protected;
      end
   end

   // Protect pin synchroniser
   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         wp_s1_reg <= RESET_WP_LEVEL;
         wp_s2_reg <= RESET_WP_LEVEL;
         wp_s3_reg <= RESET_WP_LEVEL;
         wp_level_reg <= RESET_WP_LEVEL;
      end
      else
      begin
         wp_s1_reg <= WP_B;
         wp_s2_reg <= wp_s1_reg;
         wp_s3_reg <= wp_s2_reg;
         if (wp_s2_reg == wp_s3_reg)
         begin
            wp_level_reg <= wp_s3_reg;
         end
      end
   end

   // Array engine state
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
         begin
            if (op_take && op_allowed)
            begin
               state_next = ST_BUSY;
            end
         end
         ST_BUSY:
         begin
            if (OP_DONE)
            begin
               state_next = ST_IDLE;
            end
         end
         default:
         begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         state_reg <= ST_IDLE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // Write-enable latch; a set in the same cycle as a clear wins
   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         write_enable_latch_reg <= RESET_LATCH;
      end
      else if (wren_take)
      begin
         write_enable_latch_reg <= 1'h1;
      end
      else if (write_disable_take || sw_take)
      begin
         write_enable_latch_reg <= 1'h0;
      end
      else if (busy && OP_DONE)
      begin
         write_enable_latch_reg <= 1'h0;
      end
   end

   // Protection level and lock bits
   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         level_reg <= RESET_LEVEL;
         lock_reg <= RESET_LOCK;
      end
      else if (sw_take && !locked)
      begin
         level_reg <= STATUS_WRITE_DATA[BIT_LEVEL_HI:BIT_LEVEL_LO];
         lock_reg <= STATUS_WRITE_DATA[BIT_LOCK];
      end
   end

   // Operation start and refusal pulses
   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         op_start_reg <= 1'h0;
         op_refused_reg <= 1'h0;
      end
      else
      begin
         op_start_reg <= op_take && op_allowed;
         op_refused_reg <= op_take && !op_allowed;
      end
   end

   // Live status word from the state flops
   always_comb
   begin
      STATUS_WORD = 8'h00;
      STATUS_WORD[BIT_BUSY] = state_reg[1];
      STATUS_WORD[BIT_LATCH] = write_enable_latch_reg;
      STATUS_WORD[BIT_LEVEL_HI:BIT_LEVEL_LO] = level_reg;
      STATUS_WORD[BIT_RSVD_HI:BIT_RSVD_LO] = RESET_RSVD;
      STATUS_WORD[BIT_LOCK] = lock_reg;
   end

   assign OP_START = op_start_reg;
   assign OP_REFUSED = op_refused_reg;

   // Checks
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RST_B);

   sequence s_accept;
      op_take && op_allowed;
   endsequence

   sequence s_finish;
      busy && OP_DONE;
   endsequence

   a_busy_on_start: assert property (s_accept |=> busy && OP_START)
      else $error("busy not raised on accepted operation");

   a_busy_on_done: assert property (s_finish |=> !STATUS_WORD[BIT_BUSY] && !STATUS_WORD[BIT_LATCH])
      else $error("busy or latch not cleared at completion");

   a_latch_refuse: assert property (OP_REQ && !busy && !write_enable_latch_reg
      |=> OP_REFUSED && !busy)
      else $error("operation accepted without write enable");

   a_latch_disable: assert property (write_disable_take && !wren_take
      |=> !STATUS_WORD[BIT_LATCH])
      else $error("write disable did not clear latch");

   a_reserved_zero: assert property (STATUS_WORD[BIT_RSVD_HI:BIT_RSVD_LO] == 2'h0)
      else $error("reserved bits not zero");

   a_lock_holds: assert property (sw_take && locked |=> $stable(level_reg) && $stable(lock_reg))
      else $error("locked protection bits changed");

   a_status_fields: assert property (sw_take && !locked && !wren_take |=>
      level_reg == $past(STATUS_WRITE_DATA[BIT_LEVEL_HI:BIT_LEVEL_LO]) && !STATUS_WORD[BIT_LATCH])
      else $error("status write fields wrong");

   a_protect_refuse: assert property (op_take && OP_KIND != OP_CHIP_ERASE && in_protected
      |=> OP_REFUSED && !busy)
      else $error("write into protected block accepted");

   a_chip_erase: assert property (op_take && OP_KIND == OP_CHIP_ERASE && level_reg != 3'h0
      |=> OP_REFUSED && !OP_START)
      else $error("chip erase accepted while protected");

   a_idle_stays: assert property (!busy && !op_take |=> !busy)
      else $error("busy without accepted operation");

endmodule

// ===== rtl/protect_decode.sv
// Decodes protection level against an array block index
`timescale 1ns/100ps
module protect_decode
   import flash_status_pkg::*;
(
   input wire logic [2:0] level,
   input wire logic [flash_status_pkg::BLOCK_W-1:0] block,
   output logic in_protected
);
   import flash_status_pkg::*;

   // Top fraction of the array ending at the highest block
   always_comb
   begin
      in_protected = ({1'h0, block} >= first_protected_block(level));
   end

endmodule

// ===== sim/flash_host_model.sv
// Host controller model issuing flash instructions
`timescale 1ns/100ps
module flash_host_model
   import flash_status_pkg::*;
(
   input wire logic clk,
   input wire logic [7:0] status,
   output logic wen = 1'h0,
   output logic wdis = 1'h0,
   output logic swr = 1'h0,
   output logic [7:0] sdata = 8'h00,
   output logic req = 1'h0,
   output array_op_t kind = OP_PAGE_PROGRAM,
   output logic [23:0] addr = 24'h000000
);
   // One-cycle strobe: 0 enable, 1 disable, 2 status write
   task automatic cmd(input int c, input logic [7:0] d);
      @(posedge clk);
      wen <= (c == 0);
      wdis <= (c == 1);
      swr <= (c == 2);
      sdata <= d;
      @(posedge clk);
      wen <= 1'h0;
      wdis <= 1'h0;
      swr <= 1'h0;
      sdata <= ~d;
      #1;
   endtask

   // Array request, issued only once the device is idle
   task automatic op(input array_op_t k, input logic [23:0] a);
      while (status[BIT_BUSY] !== 1'h0)
         @(posedge clk);
      @(posedge clk);
      req <= 1'h1;
      kind <= k;
      addr <= a;
      @(posedge clk);
      req <= 1'h0;
      addr <= ~a;
      #1;
   endtask
endmodule

// ===== sim/flash_status_and_block_protect_tb.sv
// Self-checking bench for the flash status and block protection logic
`timescale 1ns/100ps
module flash_status_and_block_protect_tb;
   import flash_status_pkg::*;
   logic clock = 1'h0;
   logic rst_b = 1'h0;
   logic wp_b = 1'h1;
   logic done = 1'h0;
   logic wen, wdis, swr, req, start, refused;
   logic [7:0] sdata, status;
   logic [23:0] addr;
   array_op_t kind;
   int err_count = 0;
   int comparisons = 0;

   initial
   begin
      forever #5 clock = ~clock;
   end

   flash_status_protect i_dut (.CLOCK(clock), .RST_B(rst_b), .WP_B(wp_b),
      .WRITE_ENABLE_CMD(wen), .WRITE_DISABLE_CMD(wdis), .STATUS_WRITE_CMD(swr),
      .STATUS_WRITE_DATA(sdata), .OP_REQ(req), .OP_KIND(kind), .OP_ADDR(addr),
      .OP_DONE(done), .STATUS_WORD(status), .OP_START(start), .OP_REFUSED(refused));

   flash_host_model i_host (.clk(clock), .status(status), .wen(wen), .wdis(wdis),
      .swr(swr), .sdata(sdata), .req(req), .kind(kind), .addr(addr));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Busy shown live, then engine completes
   task automatic finish_op();
      check({6'h0, status[1:0]}, 8'h3);
      repeat (3) @(posedge clock);
      done <= 1'h1;
      @(posedge clock);
      done <= 1'h0;
      #1;
      check({6'h0, status[1:0]}, 8'h0);
   endtask

   task automatic probe(input array_op_t k, input logic [23:0] a, input logic [7:0] exp);
      i_host.cmd(0, 8'h00);
      i_host.op(k, a);
      check({6'h0, start, refused}, exp);
      if (start === 1'h1)
         finish_op();
   endtask

   task automatic t_reset();
      #1;
      check(status, 8'h1c);
      check({6'h0, start, refused}, 8'h0);
      $display("test reset done");
   endtask

   task automatic t_wel();
      i_host.cmd(0, 8'h00);
      check(status, 8'h1e);
      i_host.cmd(1, 8'h00);
      check(status, 8'h1c);
      i_host.op(OP_SECTOR_ERASE, 24'h000000);
      check({6'h0, start, refused}, 8'h1);
      $display("test write enable done");
   endtask

   task automatic t_lock();
      i_host.cmd(0, 8'h00);
      i_host.cmd(2, 8'hff);
      check(status, 8'h9c);
      @(posedge clock);
      wp_b <= 1'h0;
      repeat (4) @(posedge clock);
      i_host.cmd(0, 8'h00);
      i_host.cmd(2, 8'h00);
      check(status, 8'h9c);
      @(posedge clock);
      wp_b <= 1'h1;
      repeat (4) @(posedge clock);
      i_host.cmd(0, 8'h00);
      i_host.cmd(2, 8'h00);
      check(status, 8'h00);
      @(posedge clock);
      rst_b <= 1'h0;
      @(posedge clock);
      rst_b <= 1'h1;
      #1;
      check(status, 8'h1c);
      $display("test lock done");
   endtask

   task automatic t_levels();
      logic [6:0] first;
      for (int lv = 0; lv < 8; lv++)
      begin
         first = (lv == 0) ? 7'h40 : (lv == 7) ? 7'h00 : 7'(64 - (1 << (lv - 1)));
         i_host.cmd(0, 8'h00);
         i_host.cmd(2, {3'h0, lv[2:0], 2'h0});
         check(status, {3'h0, lv[2:0], 2'h0});
         probe(OP_CHIP_ERASE, 24'h000000, (lv == 0) ? 8'h2 : 8'h1);
         if (lv == 0)
            probe(OP_SECTOR_ERASE, 24'h3ff000, 8'h2);
         if (first != 7'h00)
            probe(OP_PAGE_PROGRAM, {2'h0, 6'(first - 7'h1), 16'hffff}, 8'h2);
         if (first != 7'h40)
            probe(OP_BLOCK_ERASE, {2'h0, first[5:0], 16'h0000}, 8'h1);
      end
      $display("test levels done");
   endtask

   initial
   begin
      repeat (16) @(posedge clock);
      rst_b <= 1'h1;
      t_reset();
      t_wel();
      t_lock();
      t_levels();
      print_verdict();
   end

   initial
   begin
      #100000;
      err_count++;
      print_verdict();
   end
endmodule
